// file: design/mcsc_clock_stop_control.sv
// Module clock stop control: APB registers and per-peripheral gating
//
// Design decisions made here: register access over APB and the address map.
module mcsc_clock_stop_control
   import mcsc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt requests from the peripherals
   input wire logic [NUM_PERIPH-1:0] periphIrqIn,
   // Interrupt requests toward the interrupt controller
   output logic [NUM_PERIPH-1:0] periphIrqOut,
   // Clock enables to the peripherals
   output logic gateTimerAClkEn,
   output logic gateTimerCClkEn,
   output logic gateTimerFClkEn,
   output logic gateTimerGClkEn,
   output logic gateAdcClkEn,
   output logic gateSerialTwoClkEn,
   output logic gateSerialOneClkEn,
   output logic gateDisplayDriverClkEn,
   output logic gatePulseWidthModClkEn,
   output logic gateWatchdogClkEn,
   output logic gateAsyncEventCounterClkEn,
   // Freeze flags to the peripherals
   output logic [NUM_PERIPH-1:0] periphFrozen
);

   typedef struct packed {
      logic [7:0] clockStopRegOne;
      logic [7:0] clockStopRegTwo;
      logic [31:0] rdData;
      logic slvErr;
   } mcsc_state_t;

   mcsc_state_t state_q;
   mcsc_state_t state_d;

   mcsc_periph_t runBits;
   mcsc_periph_t clkEnVec;
   mcsc_periph_t frozenVec;
   mcsc_periph_t irqHeldVec;

   logic setupPhase;
   logic accessPhase;
   logic hitOne;
   logic hitTwo;
   logic hitStatus;
   logic mapped;
   logic [31:0] statusWord;

   // Address decode
   assign hitOne = (paddr == OFS_CLK_STOP_ONE);
   assign hitTwo = (paddr == OFS_CLK_STOP_TWO);
   assign hitStatus = (paddr == OFS_GATE_STATUS);
   assign mapped = hitOne | hitTwo | hitStatus;
   assign setupPhase = psel & ~penable;
   assign accessPhase = psel & penable;

   // Each peripheral takes only its own bit
   assign runBits = {state_q.clockStopRegTwo[REG_TWO_USED-1:0],
                     state_q.clockStopRegOne[REG_ONE_USED-1:0]};

   // Gate status: frozen flags and interrupts held by a frozen peripheral
   always_comb begin
      statusWord = 32'h0000_0000;
      statusWord[STAT_FROZEN_LSB +: NUM_PERIPH] = frozenVec;
      statusWord[STAT_IRQ_HELD_LSB +: NUM_PERIPH] = irqHeldVec & frozenVec;
   end

   always_comb begin
      state_d = state_q;
      // Read data and error are prepared in the setup cycle
      if (setupPhase) begin
         state_d.slvErr = ~mapped;
         state_d.rdData = 32'h0000_0000;
         if (!pwrite) begin
            if (hitOne) begin
               state_d.rdData = {24'h00_0000, state_q.clockStopRegOne};
            end else if (hitTwo) begin
               state_d.rdData = {24'h00_0000, state_q.clockStopRegTwo};
            end else if (hitStatus) begin
               state_d.rdData = statusWord;
            end else begin
               state_d.rdData = 32'h0000_0000;
            end
         end
      end
      // Writes take effect at the access edge, low byte lane only
      if (accessPhase && pwrite && pstrb[0]) begin
         if (hitOne) begin
            state_d.clockStopRegOne = pwdata[7:0];
         end else if (hitTwo) begin
            state_d.clockStopRegTwo = pwdata[7:0];
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q.clockStopRegOne <= RST_CLK_STOP;
         state_q.clockStopRegTwo <= RST_CLK_STOP;
         state_q.rdData <= 32'h0000_0000;
         state_q.slvErr <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   // Zero wait states: every access completes in its first access cycle
   assign pready = 1'b1;
   assign prdata = state_q.rdData;
   assign pslverr = accessPhase & state_q.slvErr;

   // One gate per peripheral
   for (genvar i = 0; i < NUM_PERIPH; i++) begin : g_gate
      mcsc_clock_gate u_gate (
         .sys_clk(sys_clk),
         .srst(srst),
         .runBit(runBits[i]),
         .irqIn(periphIrqIn[i]),
         .clkEn(clkEnVec[i]),
         .frozen(frozenVec[i]),
         .irqOut(periphIrqOut[i])
      );
   end

   assign irqHeldVec = periphIrqOut;
   assign periphFrozen = frozenVec;

   // Named clock enables, register one
   assign gateTimerAClkEn = clkEnVec[BIT_GATE_TIMER_A];
   assign gateTimerCClkEn = clkEnVec[BIT_GATE_TIMER_C];
   assign gateTimerFClkEn = clkEnVec[BIT_GATE_TIMER_F];
   assign gateTimerGClkEn = clkEnVec[BIT_GATE_TIMER_G];
   assign gateAdcClkEn = clkEnVec[BIT_GATE_ADC];
   assign gateSerialTwoClkEn = clkEnVec[BIT_GATE_SERIAL_TWO];
   assign gateSerialOneClkEn = clkEnVec[BIT_GATE_SERIAL_ONE];

   // Named clock enables, register two
   assign gateDisplayDriverClkEn =
      clkEnVec[REG_ONE_USED + BIT_GATE_DISPLAY_DRIVER];
   assign gatePulseWidthModClkEn =
      clkEnVec[REG_ONE_USED + BIT_GATE_PULSE_WIDTH_MOD];
   assign gateWatchdogClkEn =
      clkEnVec[REG_ONE_USED + BIT_GATE_WATCHDOG];
   assign gateAsyncEventCounterClkEn =
      clkEnVec[REG_ONE_USED + BIT_GATE_ASYNC_EVENT_COUNTER];

endmodule : mcsc_clock_stop_control

// file: design/mcsc_pkg.sv
// Constants and types shared by the module clock stop control block
// What this block does
// - A peripheral whose clock stop bit is 0 gets no clock and halts.
// - Writing 1 to a clock stop bit restores that peripheral's clock.
// - Both clock stop registers reset to all ones; every peripheral clocked.
// - Register one gates timers A, C, F, G, the ADC and both serials.
// - Register two gates display driver, PWM, watchdog and event counter.
// - Each peripheral is gated only by its own bit, independently.
// - A gated peripheral is frozen exactly as in chip-wide standby.
// - An interrupt request pending at gating stays asserted while frozen.
package mcsc_pkg;

   // APB register map (byte addresses)
   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] OFS_CLK_STOP_ONE = 12'h000;
   localparam logic [ADDR_W-1:0] OFS_CLK_STOP_TWO = 12'h004;
   localparam logic [ADDR_W-1:0] OFS_GATE_STATUS = 12'h008;

   // Reset values
   localparam logic [7:0] RST_CLK_STOP = 8'hff;

   // Bit positions in clock_stop_reg_one
   localparam int BIT_GATE_TIMER_A = 0;
   localparam int BIT_GATE_TIMER_C = 1;
   localparam int BIT_GATE_TIMER_F = 2;
   localparam int BIT_GATE_TIMER_G = 3;
   localparam int BIT_GATE_ADC = 4;
   localparam int BIT_GATE_SERIAL_TWO = 5;
   localparam int BIT_GATE_SERIAL_ONE = 6;
   localparam int REG_ONE_USED = 7;

   // Bit positions in clock_stop_reg_two
   localparam int BIT_GATE_DISPLAY_DRIVER = 0;
   localparam int BIT_GATE_PULSE_WIDTH_MOD = 1;
   localparam int BIT_GATE_WATCHDOG = 2;
   localparam int BIT_GATE_ASYNC_EVENT_COUNTER = 3;
   localparam int REG_TWO_USED = 4;

   // Peripheral vector: register one bits low, register two bits above
   localparam int NUM_PERIPH = REG_ONE_USED + REG_TWO_USED;

   // Gate status register fields
   localparam int STAT_FROZEN_LSB = 0;
   localparam int STAT_IRQ_HELD_LSB = 16;

   typedef logic [NUM_PERIPH-1:0] mcsc_periph_t;

endpackage : mcsc_pkg

// file: design/mcsc_clock_gate.sv
// One peripheral's clock enable, freeze flag and interrupt hold
module mcsc_clock_gate
   import mcsc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Control from the clock stop register bit (0 stops the clock)
   input wire logic runBit,
   // Peripheral interrupt request as raised by the peripheral
   input wire logic irqIn,
   // Toward the peripheral and the interrupt controller
   output logic clkEn,
   output logic frozen,
   output logic irqOut
);

   typedef struct packed {
      logic clkEn;
      logic irqLatched;
   } mcsc_gate_state_t;

   mcsc_gate_state_t state_q;
   mcsc_gate_state_t state_d;

   always_comb begin
      state_d = state_q;
      // Enable follows the bit only at a clock edge, so never a runt pulse
      state_d.clkEn = runBit;
      // Track the request while running, hold it while frozen
      if (state_q.clkEn) begin
         state_d.irqLatched = irqIn;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         state_q.clkEn <= 1'b1;
         state_q.irqLatched <= 1'b0;
      end else begin
         state_q <= state_d;
      end
   end

   assign clkEn = state_q.clkEn;
   // Frozen is the same held state a chip-wide standby gives
   assign frozen = ~state_q.clkEn;
   assign irqOut = state_q.clkEn ? irqIn : state_q.irqLatched;

endmodule : mcsc_clock_gate

// file: dv/mcsc_properties.sv
// Assertions on the ports of the module clock stop control block
module mcsc_checker
   import mcsc_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // APB requests
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   // Gating outputs
   input wire logic [NUM_PERIPH-1:0] periphIrqOut,
   input wire logic [NUM_PERIPH-1:0] periphFrozen,
   input wire logic gateTimerAClkEn,
   input wire logic gateAdcClkEn,
   input wire logic gateSerialOneClkEn,
   input wire logic gateDisplayDriverClkEn,
   input wire logic gateAsyncEventCounterClkEn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic wrOne;
   logic wrTwo;
   logic wr;
   assign wr = psel && penable && pwrite && pstrb[0];
   assign wrOne = wr && paddr == OFS_CLK_STOP_ONE;
   assign wrTwo = wr && paddr == OFS_CLK_STOP_TWO;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   property p_stop;
      wrOne && !pwdata[0] |-> ##2 !gateTimerAClkEn;
   endproperty
   a_stop: assert property (p_stop)
      else $error("clock not stopped");
   property p_run;
      wrTwo && pwdata[0] |-> ##2 gateDisplayDriverClkEn;
   endproperty
   a_run: assert property (p_run)
      else $error("clock not resumed");
   property p_rst;
      $fell(srst) |-> periphFrozen == '0 && gateAdcClkEn;
   endproperty
   a_rst: assert property (p_rst)
      else $error("not clocked after reset");
   property p_one;
      wrOne |-> ##2 gateSerialOneClkEn == $past(pwdata[6], 2);
   endproperty
   a_one: assert property (p_one)
      else $error("serial gate wrong");
   property p_two;
      wrTwo |-> ##2 gateAsyncEventCounterClkEn == $past(pwdata[3], 2);
   endproperty
   a_two: assert property (p_two)
      else $error("counter gate wrong");
   property p_ind;
      (!wrOne && !wrTwo)[*2] |=> $stable(periphFrozen);
   endproperty
   a_ind: assert property (p_ind)
      else $error("gate changed alone");
   property p_frz;
      wrOne |-> ##2 periphFrozen[4] == !$past(pwdata[4], 2)
         && periphFrozen[4] == !gateAdcClkEn;
   endproperty
   a_frz: assert property (p_frz)
      else $error("freeze flag wrong");
   property p_irq;
      ((periphIrqOut ^ $past(periphIrqOut)) & periphFrozen
         & $past(periphFrozen)) == '0;
   endproperty
   a_irq: assert property (p_irq)
      else $error("held request moved");
   property p_sync;
      $changed(gateAdcClkEn) |-> $past(wrOne, 2);
   endproperty
   a_sync: assert property (p_sync)
      else $error("enable glitch");
endmodule : mcsc_checker

bind mcsc_clock_stop_control mcsc_checker i_mcsc_checker (
   .sys_clk(sys_clk),
   .srst(srst),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .periphIrqOut(periphIrqOut),
   .periphFrozen(periphFrozen),
   .gateTimerAClkEn(gateTimerAClkEn),
   .gateAdcClkEn(gateAdcClkEn),
   .gateSerialOneClkEn(gateSerialOneClkEn),
   .gateDisplayDriverClkEn(gateDisplayDriverClkEn),
   .gateAsyncEventCounterClkEn(gateAsyncEventCounterClkEn)
);

// file: dv/mcsc_clock_stop_control_tb.sv
// Testbench for the module clock stop control block
module mcsc_clock_stop_control_tb
   import mcsc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, err;
   logic [ADDR_W-1:0] paddr = '0, a;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr;
   logic [NUM_PERIPH-1:0] periphIrqIn = '0, periphIrqOut, periphFrozen;
   logic gateTimerAClkEn, gateTimerCClkEn, gateTimerFClkEn, gateTimerGClkEn;
   logic gateAdcClkEn, gateSerialTwoClkEn, gateSerialOneClkEn;
   logic gateDisplayDriverClkEn, gatePulseWidthModClkEn, gateWatchdogClkEn;
   logic gateAsyncEventCounterClkEn;
   int fails = 0, checksDone = 0, cyc = 0, b;
   logic [NUM_PERIPH-1:0] ens;
   mcsc_clock_stop_control i_mcsc_clock_stop_control (
      .sys_clk(sys_clk),
      .srst(srst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .periphIrqIn(periphIrqIn),
      .periphIrqOut(periphIrqOut),
      .gateTimerAClkEn(gateTimerAClkEn),
      .gateTimerCClkEn(gateTimerCClkEn),
      .gateTimerFClkEn(gateTimerFClkEn),
      .gateTimerGClkEn(gateTimerGClkEn),
      .gateAdcClkEn(gateAdcClkEn),
      .gateSerialTwoClkEn(gateSerialTwoClkEn),
      .gateSerialOneClkEn(gateSerialOneClkEn),
      .gateDisplayDriverClkEn(gateDisplayDriverClkEn),
      .gatePulseWidthModClkEn(gatePulseWidthModClkEn),
      .gateWatchdogClkEn(gateWatchdogClkEn),
      .gateAsyncEventCounterClkEn(gateAsyncEventCounterClkEn),
      .periphFrozen(periphFrozen)
   );
   // Clock enables in peripheral index order
   assign ens = {gateAsyncEventCounterClkEn, gateWatchdogClkEn,
                 gatePulseWidthModClkEn, gateDisplayDriverClkEn,
                 gateSerialOneClkEn, gateSerialTwoClkEn, gateAdcClkEn,
                 gateTimerGClkEn, gateTimerFClkEn, gateTimerCClkEn,
                 gateTimerAClkEn};
   always #5 sys_clk = ~sys_clk;
   task give_verdict;
      $display("checks %0d mismatches %0d", checksDone, fails);
      if (fails == 0 && checksDone > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         give_verdict();
      end
   end
   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   task apb(input logic w, input logic [ADDR_W-1:0] ad,
            input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task frz(input logic [31:0] exp);
      repeat (2) @(posedge sys_clk);
      chk("frozen", {21'h0, periphFrozen}, exp);
      chk("enables", {21'h0, ens}, 32'h7ff ^ exp);
   endtask : frz
   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      apb(1'b0, OFS_CLK_STOP_ONE, 32'h0);
      chk("reg one", rd, 32'hff);
      apb(1'b0, OFS_CLK_STOP_TWO, 32'h0);
      chk("reg two", rd, 32'hff);
      frz(32'h0);
      $display("reset test done");
      for (int i = 0; i < NUM_PERIPH; i++) begin
         a = i < REG_ONE_USED ? OFS_CLK_STOP_ONE : OFS_CLK_STOP_TWO;
         b = i < REG_ONE_USED ? i : i - REG_ONE_USED;
         apb(1'b1, a, 32'hff ^ (32'h1 << b));
         frz(32'h1 << i);
         apb(1'b0, a, 32'h0);
         chk("readback", rd, 32'hff ^ (32'h1 << b));
         apb(1'b1, a, 32'hff);
         frz(32'h0);
      end
      $display("gating test done");
      periphIrqIn <= '1;
      apb(1'b1, OFS_CLK_STOP_TWO, 32'hfb);
      frz(32'h200);
      periphIrqIn <= '0;
      frz(32'h200);
      chk("held irq", {21'h0, periphIrqOut}, 32'h200);
      apb(1'b0, OFS_GATE_STATUS, 32'h0);
      chk("status", rd, 32'h0200_0200);
      apb(1'b1, OFS_CLK_STOP_TWO, 32'hff);
      frz(32'h0);
      chk("released irq", {21'h0, periphIrqOut}, 32'h0);
      $display("interrupt test done");
      apb(1'b1, OFS_CLK_STOP_ONE, 32'h0);
      frz(32'h7f);
      srst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      apb(1'b0, OFS_CLK_STOP_ONE, 32'h0);
      chk("reg one again", rd, 32'hff);
      frz(32'h0);
      $display("second reset test done");
      apb(1'b1, 12'h00c, 32'h0);
      chk("write error", {31'h0, err}, 32'h1);
      apb(1'b0, 12'h00c, 32'h0);
      chk("read error", {31'h0, err}, 32'h1);
      chk("unmapped", rd, 32'h0);
      pstrb <= 4'h0;
      apb(1'b1, OFS_CLK_STOP_ONE, 32'h0);
      pstrb <= 4'hf;
      apb(1'b0, OFS_CLK_STOP_ONE, 32'h0);
      chk("no strobe", rd, 32'hff);
      $display("access test done");
      give_verdict();
   end
endmodule : mcsc_clock_stop_control_tb
